// *** dsa_pkg.sv ***
// Shared constants and types for the divide and shift unit
package dsa_pkg;

  // ----------------------------------------------------------------
  // Widths and fixed register numbers
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W   = 16;
  localparam int unsigned REG_N    = 16;
  localparam int unsigned REG_AW   = 4;
  localparam int unsigned SHAMT_W  = 4;
  localparam int unsigned DIV_STEPS = DATA_W;
  localparam logic [3:0]  QUOT_REG = 4'h0;
  localparam logic [3:0]  REM_REG  = 4'h1;
  localparam logic [15:0] REG_RST  = 16'h0000;

  // ----------------------------------------------------------------
  // Operation codes and sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    DSA_OP_NONE = 3'h0,
    DSA_OP_ASR  = 3'h1,
    DSA_OP_SL   = 3'h2,
    DSA_OP_LSR  = 3'h3,
    DSA_OP_DIV  = 3'h4
  } dsa_op_t;

  typedef enum logic [2:0] {
    DSA_ST_IDLE = 3'b001,
    DSA_ST_RUN  = 3'b010,
    DSA_ST_FIX  = 3'b100
  } dsa_state_t;

endpackage

// *** dsa_shifter.sv ***
// Single-cycle barrel shifter for the three shift operations
`timescale 1ns/100ps
module dsa_shifter #(
  parameter int unsigned W  = 16,
  parameter int unsigned SW = 4
) (
  input  wire logic [W-1:0]  src,
  input  wire logic [SW-1:0] amount,
  input  wire logic [2:0]    op,
  output logic      [W-1:0]  result
);
  always_comb begin
    unique case (op)
      dsa_pkg::DSA_OP_ASR: result = W'($signed(src) >>> amount);
      dsa_pkg::DSA_OP_SL:  result = W'(src << amount);
      dsa_pkg::DSA_OP_LSR: result = W'(src >> amount);
      default:             result = src;
    endcase
  end
endmodule // dsa_shifter

// *** dsa_divide_shift_alu.sv ***
// Divide and multi-bit shift unit with its working register file
`timescale 1ns/100ps
module dsa_divide_shift_alu #(
  parameter int unsigned W = dsa_pkg::DATA_W
) (
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire logic                        op_valid,
  input  wire logic [2:0]                  op_code,
  input  wire logic                        div_signed,
  input  wire logic                        div_long,
  input  wire logic [dsa_pkg::REG_AW-1:0]  src_sel,
  input  wire logic [dsa_pkg::REG_AW-1:0]  divisor_sel,
  input  wire logic [dsa_pkg::REG_AW-1:0]  dst_sel,
  input  wire logic [dsa_pkg::SHAMT_W-1:0] shift_amount,
  input  wire logic                        wr_valid,
  input  wire logic [dsa_pkg::REG_AW-1:0]  wr_sel,
  input  wire logic [W-1:0]                wr_data,
  input  wire logic [dsa_pkg::REG_AW-1:0]  rd_sel,
  output logic      [W-1:0]                rd_data_ff,
  output logic                             busy_ff,
  output logic                             done_ff,
  output logic                             div_zero_ff
);

  // ----------------------------------------------------------------
  // Working registers
  // ----------------------------------------------------------------
  logic [W-1:0] wreg_ff [dsa_pkg::REG_N];

  function automatic logic [W-1:0] negate(input logic [W-1:0] v);
    negate = W'(~v + 1'b1);
  endfunction

  // Divisor load and both result writes share this sign step
  function automatic logic [W-1:0] apply_sign(input logic neg, input logic [W-1:0] v);
    apply_sign = neg ? negate(v) : v;
  endfunction

  dsa_pkg::dsa_state_t state_ff;
  logic [4:0]   step_ff;
  logic [W-1:0] quo_ff;
  logic [W:0]   rem_ff;
  logic [W-1:0] dvsr_ff;
  logic         neg_q_ff;
  logic         neg_r_ff;
  logic [W-1:0] shift_res;
  logic         shift_go;

  // ----------------------------------------------------------------
  // Operand fetch
  // ----------------------------------------------------------------
  logic [dsa_pkg::REG_AW-1:0] even_sel;
  logic [W-1:0] div_lo;
  logic [W-1:0] div_hi;
  logic [W-1:0] dvsr_raw;
  logic         dvd_neg;
  logic         dvsr_neg;
  logic [2*W-1:0] dvd_mag;
  logic           start_div;

  always_comb begin
    even_sel  = {src_sel[dsa_pkg::REG_AW-1:1], 1'b0};
    div_lo    = wreg_ff[div_long ? even_sel : src_sel];
    div_hi    = div_long ? wreg_ff[even_sel | 4'h1]
                         : {W{div_signed & div_lo[W-1]}};
    dvsr_raw  = wreg_ff[divisor_sel];
    dvd_neg   = div_signed & div_hi[W-1];
    dvsr_neg  = div_signed & dvsr_raw[W-1];
    dvd_mag   = dvd_neg ? (2*W)'(~{div_hi, div_lo} + 1'b1) : {div_hi, div_lo};
    start_div = op_valid && (op_code == dsa_pkg::DSA_OP_DIV)
                && (state_ff == dsa_pkg::DSA_ST_IDLE);
    shift_go  = op_valid && (state_ff == dsa_pkg::DSA_ST_IDLE)
                && (op_code inside {dsa_pkg::DSA_OP_ASR, dsa_pkg::DSA_OP_SL,
                                    dsa_pkg::DSA_OP_LSR});
  end

  dsa_shifter #(
    .W  (W),
    .SW (dsa_pkg::SHAMT_W)
  ) u_shifter (
    .src    (wreg_ff[src_sel]),
    .amount (shift_amount),
    .op     (op_code),
    .result (shift_res)
  );

  // ----------------------------------------------------------------
  // Restoring divider: one step per divisor bit
  // ----------------------------------------------------------------
  logic [W:0] trial;
  logic       take_sub;
  logic       last_step;
  always_comb begin
    trial     = {rem_ff[W-1:0], quo_ff[W-1]} - {1'b0, dvsr_ff};
    // A remainder spilling into bit 16 always exceeds the divisor, so it
    // forces a subtract whatever the trial's top bit says.
    take_sub  = !trial[W] || rem_ff[W-1];
    last_step = (step_ff == 5'h1);
  end

  // ----------------------------------------------------------------
  // Sequencer: sixteen steps, then one cycle for the sign fix-up
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= dsa_pkg::DSA_ST_IDLE;
    end else begin
      unique case (state_ff)
        dsa_pkg::DSA_ST_IDLE: begin
          if (start_div) begin
            state_ff <= dsa_pkg::DSA_ST_RUN;
          end
        end
        dsa_pkg::DSA_ST_RUN: begin
          if (last_step) begin
            state_ff <= dsa_pkg::DSA_ST_FIX;
          end
        end
        dsa_pkg::DSA_ST_FIX: begin
          state_ff <= dsa_pkg::DSA_ST_IDLE;
        end
        default: state_ff <= dsa_pkg::DSA_ST_IDLE;
      endcase
    end
  end

  // Step counter; both dividend widths load the same count
  always_ff @(posedge clk) begin
    if (rst) begin
      step_ff <= 5'h0;
    end else if (start_div) begin
      step_ff <= 5'(dsa_pkg::DIV_STEPS);
    end else if (state_ff == dsa_pkg::DSA_ST_RUN) begin
      step_ff <= 5'(step_ff - 1'b1);
    end
  end

  // Magnitude datapath; signs are put back only in the fix-up cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      quo_ff   <= 16'h0000;
      rem_ff   <= 17'h0_0000;
      dvsr_ff  <= 16'h0000;
      neg_q_ff <= 1'b0;
      neg_r_ff <= 1'b0;
    end else if (start_div) begin
      // High half seeds the partial remainder; quotient overflow is
      // not trapped, and its result differs from the core's truncated one.
      rem_ff   <= {1'b0, dvd_mag[2*W-1:W]};
      quo_ff   <= dvd_mag[W-1:0];
      dvsr_ff  <= apply_sign(dvsr_neg, dvsr_raw);
      neg_q_ff <= dvd_neg ^ dvsr_neg;
      neg_r_ff <= dvd_neg;
    end else if (state_ff == dsa_pkg::DSA_ST_RUN) begin
      if (take_sub) begin
        rem_ff <= {1'b0, trial[W-1:0]};
        quo_ff <= {quo_ff[W-2:0], 1'b1};
      end else begin
        rem_ff <= {rem_ff[W-1:0], quo_ff[W-1]};
        quo_ff <= {quo_ff[W-2:0], 1'b0};
      end
    end
  end

  // Zero-divisor flag: taken at the start, held until the next divide
  always_ff @(posedge clk) begin
    if (rst) begin
      div_zero_ff <= 1'b0;
    end else if (start_div) begin
      div_zero_ff <= (dvsr_raw == 16'h0000);
    end
  end

  // ----------------------------------------------------------------
  // Register file writes; divide results land in fixed registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < int'(dsa_pkg::REG_N); i++) begin
        wreg_ff[i] <= dsa_pkg::REG_RST;
      end
    end else begin
      if (wr_valid && state_ff == dsa_pkg::DSA_ST_IDLE) begin
        wreg_ff[wr_sel] <= wr_data;
      end
      if (shift_go) begin
        wreg_ff[dst_sel] <= shift_res;
      end
      if (state_ff == dsa_pkg::DSA_ST_FIX) begin
        wreg_ff[dsa_pkg::QUOT_REG] <= apply_sign(neg_q_ff, quo_ff);
        wreg_ff[dsa_pkg::REM_REG]  <= apply_sign(neg_r_ff, rem_ff[W-1:0]);
      end
    end
  end

  // ----------------------------------------------------------------
  // Status and read port
  // ----------------------------------------------------------------
  // Busy covers every cycle in which a request would be refused
  always_ff @(posedge clk) begin
    if (rst) begin
      busy_ff <= 1'b0;
    end else begin
      busy_ff <= start_div || (state_ff == dsa_pkg::DSA_ST_RUN);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      done_ff <= 1'b0;
    end else begin
      done_ff <= shift_go || (state_ff == dsa_pkg::DSA_ST_FIX);
    end
  end

  // Registered read keeps the array's wide mux off the output pin
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_data_ff <= 16'h0000;
    end else begin
      rd_data_ff <= wreg_ff[rd_sel];
    end
  end

endmodule // dsa_divide_shift_alu

// *** dsa_chk_sva.sv ***
// Checker for handshake timing of the divide and shift unit
`timescale 1ns/100ps
module dsa_chk (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       op_valid,
  input wire logic [2:0] op_code,
  input wire logic       busy_ff,
  input wire logic       done_ff,
  input wire logic       div_zero_ff
);
  logic go_sh, go_dv;
  // Busy stays high through the fix-up cycle, so busy low means taken
  assign go_sh = op_valid && !busy_ff && op_code inside {3'h1, 3'h2, 3'h3};
  assign go_dv = op_valid && !busy_ff && op_code == 3'h4;
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  a_shift_done_next: assert property (go_sh |=> done_ff)
    else $error("shift not done next cycle");
  a_shift_no_busy: assert property (go_sh |=> !busy_ff)
    else $error("shift raised busy");
  a_div_run_len: assert property (go_dv |=> busy_ff [*8] ##1
    busy_ff [*8] ##1 busy_ff ##1 (!busy_ff && done_ff)) else $error("divide length wrong");
  a_busy_cause: assert property ($rose(busy_ff) |-> $past(go_dv))
    else $error("busy without divide");
  a_busy_no_done: assert property (busy_ff |-> !done_ff)
    else $error("done during divide");
  a_fix_then_done: assert property ($fell(busy_ff) |-> done_ff)
    else $error("no result after fix cycle");
  a_done_cause: assert property (done_ff |-> $past(go_sh) || $fell(busy_ff))
    else $error("done without operation");
  a_zero_at_start: assert property ($changed(div_zero_ff) |-> busy_ff)
    else $error("zero flag moved outside divide");
endmodule // dsa_chk
bind dsa_divide_shift_alu dsa_chk u_chk (.clk(clk), .rst(rst), .op_valid(op_valid),
  .op_code(op_code), .busy_ff(busy_ff), .done_ff(done_ff), .div_zero_ff(div_zero_ff));

// *** dsa_core_model.sv ***
// Core-side model: working register mirror and expected results
`timescale 1ns/100ps
module dsa_core_model;
  logic [15:0] wreg [16];
  function automatic logic [15:0] shf(logic [2:0] op, logic [15:0] s, logic [3:0] n);
    case (op)
      3'h1: return $signed(s) >>> n;
      3'h2: return s << n;
      default: return s >> n;
    endcase
  endfunction
  function automatic logic [31:0] div_ref(logic sg, logic lg, logic [31:0] a, logic [15:0] d);
    logic signed [32:0] x, y;
    if (d == 16'h0000) return {16'hffff, a[15:0]};
    x = sg ? (lg ? 33'($signed(a)) : 33'($signed(a[15:0])))
           : (lg ? {1'b0, a} : {17'h0_0000, a[15:0]});
    y = sg ? 33'($signed(d)) : {17'h0_0000, d};
    return {16'(x / y), 16'(x % y)};
  endfunction
endmodule // dsa_core_model

// *** tb.sv ***
// Self-checking bench for the divide and shift unit
`timescale 1ns/100ps
module tb;
  logic        clk, rst, op_valid, div_signed, div_long, wr_valid, rd_pend, pend_q;
  logic        busy_ff, done_ff, div_zero_ff;
  logic [2:0]  op_code;
  logic [3:0]  src_sel, divisor_sel, dst_sel, shift_amount, wr_sel, rd_sel, bs;
  logic [15:0] wr_data, rd_data_ff, a, exq [$];
  logic [31:0] r;
  int          mismatches, num_checks, seed, i, k;
  dsa_core_model u_core ();
  dsa_divide_shift_alu u_dut (.clk(clk), .rst(rst), .op_valid(op_valid), .op_code(op_code),
    .div_signed(div_signed), .div_long(div_long), .src_sel(src_sel), .divisor_sel(divisor_sel),
    .dst_sel(dst_sel), .shift_amount(shift_amount), .wr_valid(wr_valid), .wr_sel(wr_sel),
    .wr_data(wr_data), .rd_sel(rd_sel), .rd_data_ff(rd_data_ff), .busy_ff(busy_ff),
    .done_ff(done_ff), .div_zero_ff(div_zero_ff));
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  task automatic chk16(string nm, logic [15:0] ex, logic [15:0] got);
    num_checks++;
    if (got !== ex) begin
      mismatches++;
      $display("[ERR] %s exp %h got %h", nm, ex, got);
    end
  endtask
  task automatic chk1(string nm, logic ex, logic got);
    chk16(nm, {15'h0000, ex}, {15'h0000, got});
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic wr(logic [3:0] s, logic [15:0] d);
    wr_valid = 1'b1;
    wr_sel = s;
    wr_data = d;
    u_core.wreg[s] = d;
    tick();
  endtask
  task automatic rd(logic [3:0] s, logic [15:0] ex);
    rd_sel = s;
    rd_pend = 1'b1;
    exq.push_back(ex);
    tick();
    rd_pend = 1'b0;
    tick();
  endtask
  always @(posedge clk) pend_q <= rd_pend;
  always @(negedge clk) if (pend_q) chk16("rd_data", exq.pop_front(), rd_data_ff);
  task automatic sh(logic [2:0] op, logic [3:0] s, logic [3:0] dd, logic [3:0] n);
    wr_valid = 1'b0;
    op_valid = 1'b1;
    op_code = op;
    src_sel = s;
    dst_sel = dd;
    shift_amount = n;
    u_core.wreg[dd] = u_core.shf(op, u_core.wreg[s], n);
    tick();
    op_valid = 1'b0;
    chk1("done", 1'b1, done_ff);
    rd(dd, u_core.wreg[dd]);
  endtask
  // Refused shift and preload aim at register 15, so divides keep off it
  task automatic div_op(logic sg, logic lg, logic [3:0] s, logic [3:0] d);
    r = u_core.div_ref(sg, lg, lg ? {u_core.wreg[s | 4'h1], u_core.wreg[s & 4'he]}
                                  : {16'h0000, u_core.wreg[s]}, u_core.wreg[d]);
    wr_valid = 1'b0;
    op_valid = 1'b1;
    op_code = 3'h4;
    div_signed = sg;
    div_long = lg;
    src_sel = s;
    divisor_sel = d;
    tick();
    chk1("busy", 1'b1, busy_ff);
    for (k = 1; done_ff !== 1'b1 && k < 40; k++) begin
      if (k == 17) chk1("busy", 1'b1, busy_ff);
      op_valid = (k == 4 || k == 17);
      wr_valid = (k == 4);
      op_code = 3'h2;
      dst_sel = 4'hf;
      wr_sel = 4'hf;
      wr_data = ~u_core.wreg[15];
      tick();
    end
    op_valid = 1'b0;
    wr_valid = 1'b0;
    if (k == 40) begin
      mismatches++;
      stop_test();
    end
    chk16("latency", 16'h0012, 16'(k));
    chk1("busy", 1'b0, busy_ff);
    chk1("div_zero", u_core.wreg[d] == 16'h0000, div_zero_ff);
    u_core.wreg[0] = r[31:16];
    u_core.wreg[1] = r[15:0];
    rd(4'h0, r[31:16]);
    rd(4'h1, r[15:0]);
    rd(4'hf, u_core.wreg[15]);
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    {rst, seed} = {1'b1, 32'hab26};
    {op_valid, div_signed, div_long, wr_valid, rd_pend, op_code} = 8'h00;
    {src_sel, divisor_sel, dst_sel, shift_amount, wr_sel, rd_sel, wr_data} = 40'h00_0000_0000;
    repeat (8) @(posedge clk);
    #1 rst = 1'b0;
    for (i = 0; i < 16; i++) wr(4'(i), 16'($random(seed)));
    for (i = 0; i < 12; i++) sh(3'(i % 3 + 1), 4'($random(seed)), 4'($random(seed)),
      i < 3 ? 4'hf : i < 6 ? 4'h0 : 4'($random(seed)));
    $display("shift test done");
    wr(4'h7, 16'h0000);
    div_op(1'b0, 1'b0, 4'h4, 4'h7);
    for (i = 0; i < 8; i++) begin
      bs = i < 4 ? 4'h4 : 4'h8;
      a = 16'($random(seed));
      wr(bs, a);
      wr(bs + 4'h1, i[0] ? {16{a[15]}} : 16'($random(seed)) & 16'h7fff);
      wr(4'h6, 16'($random(seed)) | (i[1] && !i[0] ? 16'h8000 : 16'h0001));
      div_op(i[0], i[1], bs | {3'h0, i[2]}, 4'h6);
    end
    $display("divide test done");
    stop_test();
  end
endmodule // tb
